//--- rtl/iam_core.sv
// two-wire slave address matcher with control registers
//
// The register addresses and strobed register access were decided locally.
module iam_core
   import iam_pkg::*;
(
   input  wire logic              ref_clk_i,          // system clock
   input  wire logic              reset_i,            // sync reset, high
   input  wire logic [REG_AW-1:0] reg_addr_i,         // register address
   input  wire logic [15:0]       reg_wdata_i,        // write data
   input  wire logic              reg_write_i,        // write strobe
   input  wire logic              reg_read_i,         // read strobe
   output logic      [15:0]       reg_rdata_o,        // read data
   input  wire logic              data_line_pin_i,    // data pin level
   output logic                   data_line_pin_o,    // data pin out
   output logic                   data_line_pin_oe_o, // data pin enable
   input  wire logic              clock_line_pin_i,   // clock pin level
   output logic                   clock_line_pin_o,   // clock pin out
   output logic                   clock_line_pin_oe_o // clock pin enable
);
   iam_ctrl_t  ctrl;
   logic [9:0] mask_reg;
   logic [9:0] own_addr;
   logic [15:0] baud;
   logic       scl_m;
   logic       scl_s;
   logic       scl_q;
   logic       sda_m;
   logic       sda_s;
   logic       sda_q;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_ev;
   logic       stop_ev;
   iam_state_t state;
   iam_state_t ack_next;
   iam_state_t hit_next;
   logic [2:0] bit_cnt;
   logic [7:0] shift;
   logic       ack_phase;
   logic       ack_rx;
   logic       addressed;
   logic       read_mode;
   logic       gc_hit;
   logic       ten_hit;
   logic [7:0] byte_in;
   logic [6:0] a7;
   logic       rw;
   logic       reserved7;
   logic       upper_form;
   logic       m7;
   logic       m_up;
   logic       m_lo;
   logic       gc_byte;
   logic       hit;
   logic       take;
   logic       eval_addr;
   logic       eval_low;
   logic       rx_end;
   logic       hw_clr_tx;
   logic       hw_clr_rx;
   logic       wr_ctrl;

   // pin synchronisers and edge history
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_q <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_m <= clock_line_pin_i;
         scl_s <= scl_m;
         scl_q <= scl_s;
         sda_m <= data_line_pin_i;
         sda_s <= sda_m;
         sda_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;

   // address decision on the byte being completed
   always_comb begin
      byte_in    = {shift[6:0], sda_s};
      a7         = byte_in[7:1];
      rw         = byte_in[0];
      gc_byte    = (byte_in == 8'h00);
      reserved7  = ((a7[6:3] == RSV_LOW) && (a7 != 7'h00)) |
                   (a7[6:2] == RSV_HIGH) | ((a7 == 7'h00) & rw);
      upper_form = (a7[6:2] == UPPER_TAG);
      m7   = (((a7 ^ own_addr[6:0]) & ~mask_reg[6:0]) == 7'h00);
      m_up = (((a7[1:0] ^ own_addr[9:8]) & ~mask_reg[9:8]) == 2'h0);
      m_lo = (((byte_in ^ own_addr[7:0]) & ~mask_reg[7:0]) == 8'h00);
      hit_next = rw ? ST_TX : ST_RX;
      if (ctrl.accept_all_addresses) begin
         hit = 1'b1;
      end else if (gc_byte) begin
         hit = ctrl.general_call_accept;
      end else if (reserved7) begin
         hit = 1'b0;
      end else if (upper_form) begin
         hit = ctrl.ten_bit_address_select & m_up & (~rw | ten_hit);
         if (!rw) begin
            hit_next = ST_LOW_ADDR;
         end
      end else begin
         hit = ~ctrl.ten_bit_address_select & m7;
      end
      if (state == ST_ADDR) begin
         take = hit;
      end else if (state == ST_LOW_ADDR) begin
         take = m_lo;
      end else begin
         take = 1'b1;
      end
   end

   assign eval_addr = scl_rise && (state == ST_ADDR) && (bit_cnt == LAST_BIT);
   assign eval_low  = scl_rise && (state == ST_LOW_ADDR) && (bit_cnt == LAST_BIT);
   assign rx_end    = scl_fall && (state == ST_ACK) && ack_phase && ack_rx;
   assign hw_clr_tx = eval_addr && hit && rw;
   assign hw_clr_rx = rx_end && ctrl.stretch_allow;
   assign wr_ctrl   = reg_write_i && (reg_addr_i == OFS_CTRL);

   // link state machine
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !ctrl.module_on) begin
         state              <= ST_IDLE;
         ack_next           <= ST_IDLE;
         bit_cnt            <= 3'h0;
         shift              <= 8'h00;
         ack_phase          <= 1'b0;
         ack_rx             <= 1'b0;
         data_line_pin_oe_o <= 1'b0;
      end else if (start_ev) begin
         state              <= ST_ADDR;
         bit_cnt            <= 3'h0;
         ack_phase          <= 1'b0;
         data_line_pin_oe_o <= 1'b0;
      end else if (stop_ev) begin
         state              <= ST_IDLE;
         ack_phase          <= 1'b0;
         data_line_pin_oe_o <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE, ST_TX: begin
            end
            ST_ADDR, ST_LOW_ADDR, ST_RX: begin
               if (scl_rise) begin
                  shift   <= byte_in;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == LAST_BIT) begin
                     ack_rx <= (state == ST_RX);
                     if (!take) begin
                        state <= ST_IDLE;
                     end else begin
                        state <= ST_ACK;
                        if (state == ST_ADDR) begin
                           ack_next <= hit_next;
                        end else begin
                           ack_next <= ST_RX;
                        end
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (!ack_phase) begin
                     data_line_pin_oe_o <= 1'b1;
                     ack_phase          <= 1'b1;
                  end else begin
                     data_line_pin_oe_o <= 1'b0;
                     ack_phase          <= 1'b0;
                     state              <= ack_next;
                     bit_cnt            <= 3'h0;
                  end
               end
            end
         endcase
      end
   end

   // transfer flags shown in status
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !ctrl.module_on) begin
         addressed <= 1'b0;
         read_mode <= 1'b0;
         gc_hit    <= 1'b0;
         ten_hit   <= 1'b0;
      end else if (stop_ev) begin
         addressed <= 1'b0;
         ten_hit   <= 1'b0;
      end else if (start_ev) begin
         addressed <= 1'b0;
      end else if (eval_addr && hit) begin
         addressed <= (hit_next != ST_LOW_ADDR);
         read_mode <= rw;
         gc_hit    <= gc_byte & ~ctrl.accept_all_addresses;
         if (hit_next == ST_LOW_ADDR) begin
            ten_hit <= 1'b1;
         end
      end else if (eval_low && m_lo) begin
         addressed <= 1'b1;
      end
   end

   // register writes; hardware clear of release wins over software
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ctrl     <= iam_ctrl_t'(CTRL_RESET);
         mask_reg <= ADDR_RESET;
         own_addr <= ADDR_RESET;
         baud     <= BAUD_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl <= iam_ctrl_t'(reg_wdata_i & CTRL_WMASK);
            if (ctrl.stretch_allow) begin
               ctrl.clock_line_release <= reg_wdata_i[RELEASE_BIT];
            end else begin
               ctrl.clock_line_release <= ctrl.clock_line_release | reg_wdata_i[RELEASE_BIT];
            end
         end
         if (hw_clr_tx || hw_clr_rx) begin
            ctrl.clock_line_release <= 1'b0;
         end
         if (reg_write_i && (reg_addr_i == OFS_MASK)) begin
            mask_reg <= reg_wdata_i[9:0];
         end
         if (reg_write_i && (reg_addr_i == OFS_ADDR)) begin
            own_addr <= reg_wdata_i[9:0];
         end
         if (reg_write_i && (reg_addr_i == OFS_BAUD)) begin
            baud <= reg_wdata_i;
         end
      end
   end

   // clock hold and pin levels
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         clock_line_pin_oe_o <= 1'b0;
         clock_line_pin_o    <= 1'b0;
         data_line_pin_o     <= 1'b0;
      end else begin
         clock_line_pin_oe_o <= ctrl.module_on & ~ctrl.clock_line_release;
         clock_line_pin_o    <= 1'b0;
         data_line_pin_o     <= 1'b0;
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !reg_read_i) begin
         reg_rdata_o <= 16'h0000;
      end else begin
         case (reg_addr_i)
            OFS_CTRL: reg_rdata_o <= ctrl;
            OFS_MASK: reg_rdata_o <= {6'h00, mask_reg};
            OFS_ADDR: reg_rdata_o <= {6'h00, own_addr};
            OFS_BAUD: reg_rdata_o <= baud;
            OFS_STAT: reg_rdata_o <= {12'h000, ten_hit, gc_hit, read_mode, addressed};
            default:  reg_rdata_o <= 16'h0000;
         endcase
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   a_mask_dont_care: assert property (
      eval_addr && !ctrl.accept_all_addresses && !ctrl.ten_bit_address_select &&
      !reserved7 && !gc_byte && !upper_form &&
      (((a7 ^ own_addr[6:0]) | mask_reg[6:0]) == 7'h7f) |=> state == ST_ACK)
      else $error("masked address not taken");
   a_mask_needs_off: assert property (
      eval_addr && !ctrl.accept_all_addresses && !gc_byte &&
      (((a7 ^ own_addr[6:0]) & ~mask_reg[6:0]) != 7'h00) && !upper_form
      |=> state == ST_IDLE)
      else $error("unmasked mismatch taken");
   a_reserved_no_ack: assert property (
      eval_addr && !ctrl.accept_all_addresses && reserved7
      |=> state == ST_IDLE ##1 !data_line_pin_oe_o)
      else $error("reserved address taken");
   a_general_call: assert property (
      eval_addr && gc_byte && !ctrl.accept_all_addresses
      |=> (state == ST_ACK) == $past(ctrl.general_call_accept))
      else $error("general call gating wrong");
   a_upper_only_ten: assert property (
      eval_addr && upper_form && !ctrl.ten_bit_address_select &&
      !ctrl.accept_all_addresses |=> state == ST_IDLE)
      else $error("upper tag matched as 7-bit");
   a_module_off_pins: assert property (
      !ctrl.module_on |=> !data_line_pin_oe_o && !clock_line_pin_oe_o)
      else $error("pins driven while module off");
   a_low_byte_match: assert property (
      eval_low && (((byte_in ^ own_addr[7:0]) | mask_reg[7:0]) == 8'hff)
      |=> state == ST_ACK ##1 addressed)
      else $error("second address byte not taken");
   a_accept_all: assert property (
      eval_addr && ctrl.accept_all_addresses |=> state == ST_ACK)
      else $error("accept-all refused address");
   a_ten_rejects_7: assert property (
      eval_addr && ctrl.ten_bit_address_select && !ctrl.accept_all_addresses &&
      !upper_form && !gc_byte |=> state == ST_IDLE)
      else $error("7-bit match in 10-bit mode");
   a_release_set_only: assert property (
      wr_ctrl && !reg_wdata_i[RELEASE_BIT] && !ctrl.stretch_allow &&
      ctrl.clock_line_release && !hw_clr_tx |=> ctrl.clock_line_release)
      else $error("release cleared by software");
   a_tx_holds_clock: assert property (
      hw_clr_tx && !wr_ctrl |=> !ctrl.clock_line_release ##1 clock_line_pin_oe_o)
      else $error("transmit start did not hold clock");
   a_rx_no_stretch: assert property (
      rx_end && !ctrl.stretch_allow && ctrl.clock_line_release
      |=> ctrl.clock_line_release)
      else $error("receive stretch while stretch off");
   a_rx_stretch: assert property (
      rx_end && ctrl.stretch_allow |=> !ctrl.clock_line_release)
      else $error("receive stretch missing");

   c_seven_write: cover property (eval_addr && hit && !rw && !upper_form ##1 state == ST_ACK);
   c_general_call: cover property (eval_addr && gc_byte && hit);
   c_ten_low: cover property (eval_low && m_lo);
   c_read_stretch: cover property (hw_clr_tx ##2 clock_line_pin_oe_o);
endmodule // iam_core

//--- rtl/iam_pkg.sv
// package: register map, control layout and link states for the address matcher
package iam_pkg;
   localparam int          REG_AW      = 5;
   localparam logic [4:0]  OFS_CTRL    = 5'h00;
   localparam logic [4:0]  OFS_MASK    = 5'h04;
   localparam logic [4:0]  OFS_ADDR    = 5'h08;
   localparam logic [4:0]  OFS_BAUD    = 5'h0c;
   localparam logic [4:0]  OFS_STAT    = 5'h10;
   localparam logic [15:0] CTRL_RESET  = 16'h1000;
   localparam logic [15:0] CTRL_WMASK  = 16'hbfff;
   localparam logic [15:0] BAUD_RESET  = 16'h0000;
   localparam logic [9:0]  ADDR_RESET  = 10'h000;
   localparam int          RELEASE_BIT = 12;
   localparam logic [4:0]  UPPER_TAG   = 5'h1e;
   localparam logic [4:0]  RSV_HIGH    = 5'h1f;
   localparam logic [3:0]  RSV_LOW     = 4'h0;
   localparam logic [2:0]  LAST_BIT    = 3'h7;

   typedef struct packed {
      logic module_on;
      logic unused14;
      logic halt_in_idle;
      logic clock_line_release;
      logic accept_all_addresses;
      logic ten_bit_address_select;
      logic slew_control_off;
      logic smbus_thresholds;
      logic general_call_accept;
      logic stretch_allow;
      logic ack_value;
      logic ack_sequence_go;
      logic receive_go;
      logic stop_go;
      logic repeated_start_go;
      logic start_go;
   } iam_ctrl_t;

   typedef enum {ST_IDLE, ST_ADDR, ST_LOW_ADDR, ST_ACK, ST_RX, ST_TX} iam_state_t;
endpackage : iam_pkg

//--- tb/iam_bus_master.sv
// two-wire bus master model driving the link pins
module iam_bus_master (
   input  wire logic scl_i, // clock line level
   input  wire logic sda_i, // data line level
   output logic      scl_o, // clock drive, 0 pulls low
   output logic      sda_o  // data drive, 0 pulls low
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      scl_o = 1'h1;
      sda_o = 1'h1;
   end

   // also serves as repeated start
   task automatic start();
      #50 sda_o = 1'h1;
      #50 scl_o = 1'h1;
      #100 sda_o = 1'h0;
      #100 scl_o = 1'h0;
   endtask

   task automatic stop();
      #50 sda_o = 1'h0;
      #50 scl_o = 1'h1;
      #100 sda_o = 1'h1;
      #100;
   endtask

   // msb first, ninth clock reads the ack
   task automatic xfer(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #50 sda_o = b[i];
         #50 scl_o = 1'h1;
         #100 scl_o = 1'h0;
      end
      #50 sda_o = 1'h1;
      #50 scl_o = 1'h1;
      // bounded wait while the slave stretches
      for (int n = 0; n < 100 && scl_i !== 1'h1; n++) #10;
      #50 ack = ~sda_i;
      #50 scl_o = 1'h0;
   endtask
endmodule // iam_bus_master

//--- tb/iam_core_tb_top.sv
// self-checking bench for the address matcher
module iam_core_tb_top import iam_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic              ref_clk   = 1'h0;
   logic              reset     = 1'h1;
   logic [REG_AW-1:0] reg_addr  = 5'h00;
   logic [15:0]       reg_wdata = 16'h0000;
   logic              reg_write = 1'h0;
   logic              reg_read  = 1'h0;
   logic [15:0]       reg_rdata;
   logic              sda_oe, scl_oe, sda_out, scl_out, m_sda, m_scl, ack;
   wire               sda_line  = ~(sda_oe | ~m_sda);
   wire               scl_line  = ~(scl_oe | ~m_scl);
   int                miscompares = 0;
   int                n_compared  = 0;

   always #12.5 ref_clk = ~ref_clk;

   iam_core u_dut (
      .ref_clk_i(ref_clk), .reset_i(reset), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
      .reg_rdata_o(reg_rdata), .data_line_pin_i(sda_line), .data_line_pin_o(sda_out),
      .data_line_pin_oe_o(sda_oe), .clock_line_pin_i(scl_line),
      .clock_line_pin_o(scl_out), .clock_line_pin_oe_o(scl_oe));

   iam_bus_master u_mst (.scl_i(scl_line), .sda_i(sda_line), .scl_o(m_scl), .sda_o(m_sda));

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge ref_clk);
      reg_write <= 1'h0;
   endtask

   task automatic rd(input string nm, input logic [4:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge ref_clk);
      reg_read <= 1'h0;
      #1 chk(nm, exp, reg_rdata);
   endtask

   // link edges reach the hold enable four edges late, so allow six
   task automatic hold(input logic exp);
      repeat (6) @(posedge ref_clk);
      #1 chk("clock hold", {15'h0, exp}, {15'h0, scl_oe});
      chk("pin levels", 16'h0000, {14'h0, sda_out, scl_out});
   endtask

   task automatic try(input logic [15:0] c, input logic [9:0] m, input logic [9:0] a,
                      input logic [7:0] b, input logic e);
      wr(OFS_CTRL, c);
      wr(OFS_MASK, {6'h00, m});
      wr(OFS_ADDR, {6'h00, a});
      // keep pin changes off the sampling edges of ref_clk
      #2;
      u_mst.start();
      u_mst.xfer(b, ack);
      chk("ack", {15'h0, e}, {15'h0, ack});
   endtask

   task automatic more(input logic [7:0] b, input logic e);
      u_mst.xfer(b, ack);
      chk("ack", {15'h0, e}, {15'h0, ack});
   endtask

   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      #500000;
      miscompares++;
      close_out();
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      reset <= 1'h0;
      repeat (3) @(posedge ref_clk);
      rd("control", OFS_CTRL, CTRL_RESET);
      rd("mask", OFS_MASK, 16'h0000);
      rd("address", OFS_ADDR, {6'h00, ADDR_RESET});
      rd("baud", OFS_BAUD, BAUD_RESET);
      wr(OFS_CTRL, 16'h0000);
      rd("control", OFS_CTRL, 16'h1000);
      wr(OFS_CTRL, 16'hffff);
      rd("control", OFS_CTRL, 16'hbfff);
      wr(OFS_CTRL, 16'h8040);
      rd("control", OFS_CTRL, 16'h8040);
      hold(1'h1);
      wr(OFS_CTRL, 16'h0000);
      hold(1'h0);
      wr(OFS_BAUD, 16'h009d);
      rd("baud", OFS_BAUD, 16'h009d);
      wr(OFS_MASK, 16'hffff);
      rd("mask", OFS_MASK, 16'h03ff);
      wr(5'h14, 16'hffff);
      rd("unmapped", 5'h14, 16'h0000);
      $display("test registers done");
      try(16'h9000, 10'h000, 10'h050, 8'ha0, 1'h1);
      try(16'h9000, 10'h000, 10'h050, 8'ha2, 1'h0);
      try(16'h9000, 10'h020, 10'h050, 8'he0, 1'h1);
      try(16'h9000, 10'h000, 10'h07a, 8'hf4, 1'h0);
      try(16'h9800, 10'h000, 10'h050, 8'he2, 1'h1);
      try(16'h9000, 10'h07f, 10'h000, 8'h02, 1'h0);
      try(16'h9000, 10'h07f, 10'h000, 8'h06, 1'h0);
      try(16'h9000, 10'h07f, 10'h000, 8'h0a, 1'h0);
      try(16'h9000, 10'h07f, 10'h000, 8'hf8, 1'h0);
      try(16'h9080, 10'h07f, 10'h000, 8'h01, 1'h0);
      try(16'h9000, 10'h000, 10'h000, 8'h00, 1'h0);
      try(16'h9080, 10'h000, 10'h050, 8'h00, 1'h1);
      rd("status", OFS_STAT, 16'h0005);
      try(16'h9400, 10'h000, 10'h2a5, 8'hf4, 1'h1);
      more(8'ha5, 1'h1);
      try(16'h9400, 10'h000, 10'h2a5, 8'hf6, 1'h0);
      try(16'h9400, 10'h201, 10'h2a5, 8'hf0, 1'h1);
      more(8'ha4, 1'h1);
      rd("status", OFS_STAT, 16'h0009);
      try(16'h1000, 10'h000, 10'h050, 8'ha0, 1'h0);
      chk("data drive", 16'h0000, {15'h0, sda_oe});
      u_mst.stop();
      $display("test matching done");
      // software releases the held ack clock while the master waits on it
      fork
         try(16'h9000, 10'h000, 10'h050, 8'ha1, 1'h1);
         begin
            wait (scl_oe);
            hold(1'h1);
            rd("control", OFS_CTRL, 16'h8000);
            rd("status", OFS_STAT, 16'h0003);
            wr(OFS_CTRL, 16'h9000);
            hold(1'h0);
         end
      join
      try(16'h9000, 10'h000, 10'h050, 8'ha0, 1'h1);
      more(8'h5a, 1'h1);
      hold(1'h0);
      try(16'h9040, 10'h000, 10'h050, 8'ha0, 1'h1);
      more(8'h5a, 1'h1);
      hold(1'h1);
      wr(OFS_CTRL, 16'h9040);
      hold(1'h0);
      u_mst.stop();
      $display("test stretching done");
      close_out();
   end
endmodule // iam_core_tb_top
